// [core/psp_rx.sv]
`timescale 1ns/1ps
module psp_rx import psp_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  psp_link_if.receiver           link,
  input  wire logic              plc_chan_en,
  input  wire logic [CH_W-1:0]   plc_chan,
  output logic                   hdr_valid,
  output logic [FLOW_W-1:0]      hdr_flow,
  output logic [SEQ_W-1:0]       hdr_seq,
  output logic                   hdr_seq_ok,
  output logic                   pkt_lost,
  output logic                   desc_valid,
  output logic [CH_W-1:0]        desc_chan,
  output logic [LEN_W-1:0]       desc_len,
  output logic                   desc_sof,
  output logic                   desc_eof,
  output logic                   desc_mb,
  output logic                   desc_ts,
  output logic [PROF_W-1:0]      desc_profile,
  output logic                   desc_err,
  output logic                   pay_valid,
  input  wire logic              pay_ready,
  output logic [WORD_W-1:0]      pay_data,
  output logic                   pay_last,
  output logic [TAIL_W-1:0]      pay_tail,
  output logic                   pkt_done,
  output logic                   pkt_bad
);
  typedef struct packed {
    rx_state_e         state;
    logic              rdy;
    logic              hdr_valid;
    logic [FLOW_W-1:0] flow;
    logic [SEQ_W-1:0]  seq;
    logic              seq_ok;
    logic [SEQ_W-1:0]  exp_seq;
    logic              seq_seen;
    logic              lost;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  idx;
    logic [BYTES_W-1:0] sum_len;
    logic [BYTES_W-1:0] bytes;
    logic              d_valid;
    logic [CH_W-1:0]   d_chan;
    logic [LEN_W-1:0]  d_len;
    logic              d_sof;
    logic              d_eof;
    logic              d_mb;
    logic              d_ts;
    logic [PROF_W-1:0] d_prof;
    logic              d_err;
    logic              p_valid;
    logic [WORD_W-1:0] p_data;
    logic              p_last;
    logic [TAIL_W-1:0] p_tail;
    logic              done;
    logic              bad;
  } rx_s;

  typedef struct packed {
    logic              open;
    logic              seen;
    logic [CSEQ_W-1:0] exp;
  } chan_s;

  function automatic logic [2:0] word_bytes(input logic last, input logic [TAIL_W-1:0] tail);
    word_bytes = (last && tail != '0) ? {1'b0, tail} : FULL_WORD;
  endfunction

  rx_s              r_q;
  rx_s              r_d;
  chan_s            chan_mem [CH_DEPTH];
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  chan_s            wr_val;

  always_comb begin
    logic              take;
    logic [WORD_W-1:0] w;
    logic [CH_W-1:0]   ch;
    logic              mb;
    logic              b;
    logic              e;
    logic [CSEQ_W-1:0] cs;
    chan_s             cst;
    logic [BYTES_W-1:0] nb;
    take   = link.valid && r_q.rdy;
    w      = link.data;
    ch     = w[CH_LO+CH_W-1:CH_LO];
    b      = w[BIT_B];
    e      = w[BIT_E];
    cs     = w[CSEQ_LO+CSEQ_W-1:CSEQ_LO];
    mb     = plc_chan_en && ch == plc_chan && w[BIT_T]; // see RULE_22
    cst    = chan_mem[{r_q.flow, ch}];
    nb     = r_q.bytes + BYTES_W'(word_bytes(link.last, link.tail));
    r_d    = r_q;
    wr_en  = 1'b0;
    wr_idx = {r_q.flow, ch};
    wr_val = cst;
    r_d.hdr_valid = 1'b0;
    r_d.lost      = 1'b0;
    r_d.d_valid   = 1'b0;
    r_d.done      = 1'b0;
    if (r_q.p_valid && pay_ready) begin
      r_d.p_valid = 1'b0;
    end
    unique case (r_q.state)
      RX_HDR: begin
        if (take) begin
          r_d.sum_len = '0;
          r_d.bytes   = '0;
          r_d.idx     = '0;
          // first bit and reserved bit are not looked at; see RULE_01, RULE_05
          if (w[H_LO+1:H_LO] != H_MATCH) begin // see RULE_03, RULE_18
            r_d.done  = link.last;
            r_d.bad   = 1'b1;
            r_d.state = link.last ? RX_HDR : RX_DROP;
          end else begin
            r_d.hdr_valid = 1'b1;
            r_d.flow   = w[FLOW_LO+FLOW_W-1:FLOW_LO]; // see RULE_04, RULE_17
            r_d.count  = w[CNT_LO+CNT_W-1:CNT_LO]; // see RULE_06
            r_d.seq    = w[SEQ_LO+SEQ_W-1:SEQ_LO]; // see RULE_07
            r_d.seq_ok = w[BIT_S];
            if (w[BIT_S]) begin // see RULE_02
              r_d.lost     = r_q.seq_seen && w[SEQ_LO+SEQ_W-1:SEQ_LO] != r_q.exp_seq; // see RULE_19
              r_d.exp_seq  = w[SEQ_LO+SEQ_W-1:SEQ_LO] + 1'b1;
              r_d.seq_seen = 1'b1;
            end
            r_d.bad = 1'b0;
            if (link.last) begin
              r_d.done = 1'b1;
              r_d.bad  = (w[CNT_LO+CNT_W-1:CNT_LO] != '0);
            end else begin
              r_d.state = (w[CNT_LO+CNT_W-1:CNT_LO] == '0) ? RX_PAY : RX_TABLE;
            end
          end
        end
      end
      RX_TABLE: begin
        if (take) begin
          r_d.d_valid = 1'b1; // see RULE_08, RULE_20
          r_d.d_chan  = ch;
          r_d.d_len   = w[LEN_LO+LEN_W-1:LEN_LO];
          r_d.d_mb    = mb;
          r_d.d_sof   = !mb && b; // see RULE_09, RULE_10
          r_d.d_eof   = !mb && e; // see RULE_12, RULE_13
          r_d.d_ts    = mb && b; // see RULE_11, RULE_16
          r_d.d_prof  = w[PROF_LO+PROF_W-1:PROF_LO];
          // frame continuity across packets and lost segment detection
          r_d.d_err = (!mb && (b == cst.open)) || (cst.seen && cs != cst.exp); // see RULE_15, RULE_21
          wr_en       = 1'b1;
          wr_val.open = mb ? cst.open : !e; // see RULE_15
          wr_val.seen = 1'b1;
          wr_val.exp  = cs + 1'b1; // see RULE_21
          r_d.sum_len = r_q.sum_len + BYTES_W'(w[LEN_LO+LEN_W-1:LEN_LO]);
          r_d.idx     = r_q.idx + 1'b1;
          if (link.last) begin
            r_d.done  = 1'b1;
            r_d.bad   = 1'b1; // see RULE_23
            r_d.state = RX_HDR;
          end else if (r_q.idx == r_q.count - 1'b1) begin
            r_d.state = RX_PAY;
          end
        end
      end
      RX_PAY: begin
        if (take) begin
          r_d.p_valid = 1'b1;
          r_d.p_data  = w;
          r_d.p_last  = link.last;
          r_d.p_tail  = link.tail;
          r_d.bytes   = nb;
          if (link.last) begin
            r_d.done  = 1'b1;
            r_d.bad   = (nb != r_q.sum_len); // see RULE_23
            r_d.state = RX_HDR;
          end
        end
      end
      RX_DROP: begin
        if (take && link.last) begin
          r_d.done  = 1'b1;
          r_d.state = RX_HDR;
        end
      end
    endcase
    r_d.rdy = !r_d.p_valid;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_q       <= '0;
      r_q.state <= RX_HDR;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CH_DEPTH; i++) begin
        chan_mem[i] <= '0;
      end
    end else if (wr_en) begin
      chan_mem[wr_idx] <= wr_val;
    end
  end

  assign link.ready   = r_q.rdy;
  assign hdr_valid    = r_q.hdr_valid;
  assign hdr_flow     = r_q.flow;
  assign hdr_seq      = r_q.seq;
  assign hdr_seq_ok   = r_q.seq_ok;
  assign pkt_lost     = r_q.lost;
  assign desc_valid   = r_q.d_valid;
  assign desc_chan    = r_q.d_chan;
  assign desc_len     = r_q.d_len;
  assign desc_sof     = r_q.d_sof;
  assign desc_eof     = r_q.d_eof;
  assign desc_mb      = r_q.d_mb;
  assign desc_ts      = r_q.d_ts;
  assign desc_profile = r_q.d_prof;
  assign desc_err     = r_q.d_err;
  assign pay_valid    = r_q.p_valid;
  assign pay_data     = r_q.p_data;
  assign pay_last     = r_q.p_last;
  assign pay_tail     = r_q.p_tail;
  assign pkt_done     = r_q.done;
  assign pkt_bad      = r_q.bad;
endmodule

// [core/psp_pkg.sv]
// Functional notes
// (RULE_01) sender always sends the first header bit zero
// (RULE_02) sequence-valid flag marks a usable sequence number
// (RULE_03) extended-header bits are 00 for this pseudowire
// (RULE_04) three-bit flow selector carried in header
// (RULE_05) reserved bit sent zero, ignored on receive
// (RULE_06) seven-bit segment count equals table entries
// (RULE_07) sixteen-bit sequence number before segment table
// (RULE_08) entries are 32 bits with channel, seq, profile
// (RULE_09) entry marks begin, middle, end or whole frame
// (RULE_10) begin flag set on first part of frame
// (RULE_11) message block begin flag means prepended timestamp
// (RULE_12) end flag set on last part of frame
// (RULE_13) message block end flag sent zero, ignored
// (RULE_14) only first and last frame may be split
// (RULE_15) receiver tracks frames spread over many packets
// (RULE_16) message blocks always carried whole
// (RULE_17) one header layout for every channel type
// (RULE_18) legacy 16-bit entry header never used
// (RULE_19) sequence starts random; receiver detects lost packets
// (RULE_20) 14-bit length and channel selector every entry
// (RULE_21) per-channel sequence increments per flow and channel
// (RULE_22) profile field zero or segment type bit; OFDM begin entries carry desc_profile instead
// (RULE_23) receiver checks payload length against segment lengths
package psp_pkg;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned FLOW_W    = 3;
  localparam int unsigned CNT_W     = 7;
  localparam int unsigned SEQ_W     = 16;
  localparam int unsigned LEN_W     = 14;
  localparam int unsigned CH_W      = 8;
  localparam int unsigned CSEQ_W    = 4;
  localparam int unsigned PROF_W    = 4;
  localparam int unsigned TAIL_W    = 2;
  localparam int unsigned BYTES_W   = 21;
  localparam int unsigned IDX_W     = FLOW_W + CH_W;
  localparam int unsigned CH_DEPTH  = 1 << IDX_W;
  // header word
  localparam int unsigned BIT_V     = 31;
  localparam int unsigned BIT_S     = 30;
  localparam int unsigned H_LO      = 28;
  localparam int unsigned FLOW_LO   = 25;
  localparam int unsigned BIT_X     = 24;
  localparam int unsigned BIT_PAD   = 23;
  localparam int unsigned CNT_LO    = 16;
  localparam int unsigned SEQ_LO    = 0;
  // segment table entry
  localparam int unsigned BIT_B     = 31;
  localparam int unsigned BIT_E     = 30;
  localparam int unsigned LEN_LO    = 16;
  localparam int unsigned CH_LO     = 8;
  localparam int unsigned CSEQ_LO   = 4;
  localparam int unsigned PROF_LO   = 0;
  localparam int unsigned BIT_T     = 0;
  localparam logic [1:0]        H_MATCH   = 2'h0;
  localparam logic              VCCV_TX   = 1'h0;
  localparam logic              X_TX      = 1'h0;
  localparam logic [PROF_W-1:0] PROF_ZERO = 4'h0;
  localparam logic [PROF_W-1:0] PROF_MB   = 4'h1;
  localparam logic [SEQ_W-1:0]  LFSR_SEED = 16'hACE1;
  localparam logic [SEQ_W-1:0]  LFSR_TAPS = 16'hB400;
  localparam logic [2:0]        FULL_WORD = 3'h4;

  typedef enum logic [1:0] {SEG_SCQAM, SEG_OFDM, SEG_PLC_MAC, SEG_PLC_MB} seg_kind_e;
  typedef enum logic [1:0] {TX_IDLE, TX_TABLE, TX_PAY} tx_state_e;
  typedef enum logic [1:0] {RX_HDR, RX_TABLE, RX_PAY, RX_DROP} rx_state_e;
endpackage

// [core/psp_link_if.sv]
`timescale 1ns/1ps
interface psp_link_if import psp_pkg::*; ;
  logic [WORD_W-1:0] data;
  logic              valid;
  logic              ready;
  logic              last;
  logic [TAIL_W-1:0] tail;
  modport sender   (output data, output valid, output last, output tail, input ready);
  modport receiver (input data, input valid, input last, input tail, output ready);
endinterface

// [core/psp_tx.sv]
`timescale 1ns/1ps
module psp_tx import psp_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  psp_link_if.sender             link,
  input  wire logic              usr_valid,
  output logic                   usr_ready,
  input  wire logic [FLOW_W-1:0] cmd_flow,
  input  wire logic              cmd_seq_ok,
  input  wire logic [CNT_W-1:0]  cmd_count,
  input  wire seg_kind_e         desc_kind,
  input  wire logic              desc_begin,
  input  wire logic              desc_end,
  input  wire logic [LEN_W-1:0]  desc_len,
  input  wire logic [CH_W-1:0]   desc_chan,
  input  wire logic [PROF_W-1:0] desc_profile,
  input  wire logic [WORD_W-1:0] pay_data,
  input  wire logic              pay_last,
  input  wire logic [TAIL_W-1:0] pay_tail,
  output logic                   desc_err,
  output logic [SEQ_W-1:0]       tx_seq
);
  typedef struct packed {
    tx_state_e         state;
    logic [WORD_W-1:0] out_data;
    logic              out_valid;
    logic              out_last;
    logic [TAIL_W-1:0] out_tail;
    logic              rdy;
    logic [FLOW_W-1:0] flow;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  idx;
    logic [SEQ_W-1:0]  seq;
    logic              seq_started;
    logic [SEQ_W-1:0]  lfsr;
    logic              desc_err;
  } tx_s;

  tx_s               r_q;
  tx_s               r_d;
  logic [CSEQ_W-1:0] cseq_mem [CH_DEPTH];
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [CSEQ_W-1:0] wr_val;

  always_comb begin
    logic              take;
    logic [SEQ_W-1:0]  seq;
    logic [WORD_W-1:0] w;
    logic [CSEQ_W-1:0] cseq;
    logic              mb;
    logic              b;
    logic              e;
    logic [PROF_W-1:0] prof;
    take   = 1'b0;
    seq    = '0;
    w      = '0;
    cseq   = '0;
    mb     = 1'b0;
    b      = 1'b0;
    e      = 1'b0;
    prof   = PROF_ZERO;
    r_d    = r_q;
    wr_en  = 1'b0;
    wr_idx = {r_q.flow, desc_chan};
    wr_val = '0;
    r_d.lfsr     = {r_q.lfsr[SEQ_W-2:0], ^(r_q.lfsr & LFSR_TAPS)};
    r_d.desc_err = 1'b0;
    if (r_q.out_valid && link.ready) begin
      r_d.out_valid = 1'b0;
    end
    take = usr_valid && r_q.rdy;
    unique case (r_q.state)
      TX_IDLE: begin
        if (take) begin
          seq = r_q.seq_started ? r_q.seq : r_q.lfsr; // see RULE_19
          w[BIT_V] = VCCV_TX; // see RULE_01
          w[BIT_S] = cmd_seq_ok; // see RULE_02
          w[H_LO+1:H_LO] = H_MATCH; // see RULE_03
          w[FLOW_LO+FLOW_W-1:FLOW_LO] = cmd_flow; // see RULE_04
          w[BIT_X] = X_TX; // see RULE_05
          w[BIT_PAD] = 1'b0;
          w[CNT_LO+CNT_W-1:CNT_LO] = cmd_count; // see RULE_06
          w[SEQ_LO+SEQ_W-1:SEQ_LO] = seq; // see RULE_07
          r_d.out_data    = w;
          r_d.out_valid   = 1'b1;
          r_d.out_last    = (cmd_count == '0);
          r_d.out_tail    = '0;
          r_d.seq_started = 1'b1;
          r_d.seq         = cmd_seq_ok ? seq + 1'b1 : seq;
          r_d.flow        = cmd_flow;
          r_d.count       = cmd_count;
          r_d.idx         = '0;
          r_d.state       = (cmd_count == '0) ? TX_IDLE : TX_TABLE;
        end
      end
      TX_TABLE: begin
        if (take) begin
          mb   = (desc_kind == SEG_PLC_MB);
          b    = desc_begin; // see RULE_10, RULE_11
          e    = mb ? 1'b0 : desc_end; // see RULE_12, RULE_13
          cseq = cseq_mem[{r_q.flow, desc_chan}];
          unique case (desc_kind) // see RULE_22
            SEG_SCQAM:   prof = PROF_ZERO;
            SEG_OFDM:    prof = desc_begin ? desc_profile : PROF_ZERO;
            SEG_PLC_MAC: prof = PROF_ZERO;
            SEG_PLC_MB:  prof = PROF_MB;
          endcase
          w[BIT_B] = b; // see RULE_09
          w[BIT_E] = e;
          w[LEN_LO+LEN_W-1:LEN_LO] = desc_len; // see RULE_20
          w[CH_LO+CH_W-1:CH_LO] = desc_chan; // see RULE_20
          w[CSEQ_LO+CSEQ_W-1:CSEQ_LO] = cseq; // see RULE_08, RULE_17, RULE_18
          w[PROF_LO+PROF_W-1:PROF_LO] = prof;
          wr_en  = 1'b1; // see RULE_21
          wr_val = cseq + 1'b1;
          // inner frames must be whole; blocks are whole by construction
          if (!mb && r_q.idx != '0 && r_q.idx != r_q.count - 1'b1 &&
              !(desc_begin && desc_end)) begin
            r_d.desc_err = 1'b1; // see RULE_14, RULE_16
          end
          r_d.out_data  = w;
          r_d.out_valid = 1'b1;
          r_d.out_last  = 1'b0;
          r_d.out_tail  = '0;
          r_d.idx       = r_q.idx + 1'b1;
          if (r_q.idx == r_q.count - 1'b1) begin
            r_d.state = TX_PAY;
          end
        end
      end
      TX_PAY: begin
        if (take) begin
          r_d.out_data  = pay_data;
          r_d.out_valid = 1'b1;
          r_d.out_last  = pay_last;
          r_d.out_tail  = pay_tail;
          if (pay_last) begin
            r_d.state = TX_IDLE;
          end
        end
      end
    endcase
    r_d.rdy = !r_d.out_valid;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_q       <= '0;
      r_q.state <= TX_IDLE;
      r_q.lfsr  <= LFSR_SEED;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CH_DEPTH; i++) begin
        cseq_mem[i] <= '0;
      end
    end else if (wr_en) begin
      cseq_mem[wr_idx] <= wr_val;
    end
  end

  assign link.data  = r_q.out_data;
  assign link.valid = r_q.out_valid;
  assign link.last  = r_q.out_last;
  assign link.tail  = r_q.out_tail;
  assign usr_ready  = r_q.rdy;
  assign desc_err   = r_q.desc_err;
  assign tx_seq     = r_q.seq;
endmodule

// [tb/psp_codec_asserts.sv]
`timescale 1ns/1ps
module psp_codec_asserts import psp_pkg::*; (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic [WORD_W-1:0] data,
  input wire logic              valid,
  input wire logic              ready,
  input wire logic              last,
  input wire logic [TAIL_W-1:0] tail
);
  logic              hdr_q;
  logic              have_q;
  logic [CNT_W-1:0]  left_q;
  logic [FLOW_W-1:0] flow_q;
  logic [SEQ_W-1:0]  seq_q;
  logic [CSEQ_W-1:0] cs_q [CH_DEPTH];
  wire logic         take;
  assign take = valid && ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // word phase tracking and per-channel sequence shadow
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hdr_q  <= 1'b1;
      have_q <= 1'b0;
      left_q <= '0;
      for (int i = 0; i < CH_DEPTH; i++)
        cs_q[i] <= '0;
    end else if (take) begin
      hdr_q <= last;
      if (hdr_q) begin
        left_q <= data[CNT_LO+:CNT_W];
        flow_q <= data[FLOW_LO+:FLOW_W];
        if (data[BIT_S]) begin
          seq_q  <= data[SEQ_LO+:SEQ_W];
          have_q <= 1'b1;
        end
      end else if (left_q != '0) begin
        left_q <= left_q - 7'h1;
        cs_q[{flow_q, data[CH_LO+:CH_W]}] <= data[CSEQ_LO+:CSEQ_W] + 4'h1;
      end
    end
  end
  sequence s_hdr;
    take && hdr_q;
  endsequence
  sequence s_ent;
    take && !hdr_q && left_q != '0;
  endsequence
  a_vccv_bit_zero: assert property (s_hdr |-> !data[BIT_V])
    else $error("header first bit not zero");
  a_ext_bits_match: assert property (s_hdr |-> data[H_LO+:2] == H_MATCH)
    else $error("extended header bits not 00");
  a_resv_bit_zero: assert property (s_hdr |-> !data[BIT_X])
    else $error("reserved header bit not zero");
  a_count_last: assert property (s_hdr |-> last == (data[CNT_LO+:CNT_W] == '0))
    else $error("header last flag disagrees with count");
  a_entry_not_last: assert property (s_ent |-> !last)
    else $error("packet ended inside segment table");
  a_seq_step: assert property (s_hdr ##0 (data[BIT_S] && have_q)
    |-> data[SEQ_LO+:SEQ_W] == SEQ_W'(seq_q + 16'h1))
    else $error("sequence number did not step by one");
  a_chan_seq_step: assert property (s_ent
    |-> data[CSEQ_LO+:CSEQ_W] == cs_q[{flow_q, data[CH_LO+:CH_W]}])
    else $error("channel sequence did not step by one");
  a_prof_upper_zero: assert property (s_ent ##0 !data[BIT_B] |-> data[3:1] == 3'h0)
    else $error("profile upper bits set on non-begin entry");
  a_word_holds: assert property (valid && !ready |=> valid && $stable(data) && $stable(last))
    else $error("link word changed before accepted");
  c_table_pay: cover property (s_ent ##[1:40] take && last);
endmodule

// [tb/psp_sublayer_header_codec_tb.sv]
`timescale 1ns/1ps
module psp_sublayer_header_codec_tb import psp_pkg::*; ;
  logic ref_clk, sys_rst, usr_valid, usr_ready, cmd_seq_ok, desc_begin, desc_end, pay_last;
  logic pay_ready, plc_chan_en, t_derr, hdr_valid, hdr_seq_ok, pkt_lost, desc_valid, sof, eof;
  logic mb, ts, r_derr, pay_valid, r_last, pkt_done, pkt_bad, hv2, lost2, dv2, derr2, done2;
  logic bad2;
  logic [2:0]  cmd_flow, hdr_flow, flow;
  logic [6:0]  cmd_count;
  seg_kind_e   desc_kind;
  logic [13:0] desc_len, r_len;
  logic [7:0]  desc_chan, plc_chan, r_chan, pseq;
  logic [3:0]  desc_profile, r_prof, n_hdr2, n_lost2, n_bad2, n_derr2, n_done2, tx_err;
  logic [31:0] pay_data, r_data;
  logic [1:0]  pay_tail, r_tail;
  logic [15:0] hdr_seq, lseq, tseq;
  logic [34:0] m, exp_w[$], exp_m[$], exp_d[$], exp_p[$];
  logic [4:0]  exp_h[$];
  logic        exp_b[$];
  logic [3:0]  cs [2048] = '{default: 4'h0};
  int          error_cnt, n_checks, cyc;
  psp_link_if lnk ();
  psp_link_if lnk2 ();
  psp_tx u_psp_tx (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk.sender),
    .usr_valid(usr_valid), .usr_ready(usr_ready), .cmd_flow(cmd_flow), .cmd_seq_ok(cmd_seq_ok),
    .cmd_count(cmd_count), .desc_kind(desc_kind), .desc_begin(desc_begin), .desc_end(desc_end),
    .desc_len(desc_len), .desc_chan(desc_chan), .desc_profile(desc_profile),
    .pay_data(pay_data), .pay_last(pay_last), .pay_tail(pay_tail), .desc_err(t_derr),
    .tx_seq(tseq));
  psp_rx u_psp_rx (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk.receiver),
    .plc_chan_en(plc_chan_en), .plc_chan(plc_chan), .hdr_valid(hdr_valid), .hdr_flow(hdr_flow),
    .hdr_seq(hdr_seq), .hdr_seq_ok(hdr_seq_ok), .pkt_lost(pkt_lost), .desc_valid(desc_valid),
    .desc_chan(r_chan), .desc_len(r_len), .desc_sof(sof), .desc_eof(eof), .desc_mb(mb),
    .desc_ts(ts), .desc_profile(r_prof), .desc_err(r_derr), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .pay_data(r_data), .pay_last(r_last), .pay_tail(r_tail),
    .pkt_done(pkt_done), .pkt_bad(pkt_bad));
  psp_rx u_psp_rx2 (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk2.receiver),
    .plc_chan_en(plc_chan_en), .plc_chan(plc_chan), .hdr_valid(hv2), .hdr_flow(), .hdr_seq(),
    .hdr_seq_ok(), .pkt_lost(lost2), .desc_valid(dv2), .desc_chan(), .desc_len(), .desc_sof(),
    .desc_eof(), .desc_mb(), .desc_ts(), .desc_profile(), .desc_err(derr2), .pay_valid(),
    .pay_ready(1'b1), .pay_data(), .pay_last(), .pay_tail(), .pkt_done(done2), .pkt_bad(bad2));
  psp_codec_asserts u_psp_codec_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .data(lnk.data), .valid(lnk.valid), .ready(lnk.ready), .last(lnk.last), .tail(lnk.tail));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;
  always @(negedge ref_clk) pay_ready <= (cyc % 3) != 0;

  task chk(input logic [34:0] g, input logic [34:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // monitor, sampled after the falling edge when everything has settled
  always begin
    @(negedge ref_clk);
    #1;
    if (!sys_rst) begin
      if (lnk.valid && lnk.ready) begin
        chk(exp_m.size() != 0, 1'b1);
        m = exp_m.pop_front();
        if (m[15:0] == 16'h0)
          lseq = lnk.data[15:0];
        chk({lnk.last, lnk.tail, lnk.data} & m, exp_w.pop_front() & m);
      end
      if (hdr_valid) chk({hdr_flow, hdr_seq_ok, pkt_lost, hdr_seq}, {exp_h.pop_front(), lseq});
      if (hdr_valid) chk(tseq, lseq + {15'h0, hdr_seq_ok});
      if (desc_valid) chk({r_chan, r_len, sof, eof, mb, ts, r_derr, r_prof}, exp_d.pop_front());
      if (pay_valid && pay_ready) chk({r_last, r_last ? r_tail : 2'h0, r_data}, exp_p.pop_front());
      if (pkt_done) chk(pkt_bad, exp_b.pop_front());
      tx_err  += t_derr;
      n_hdr2  += hv2;
      n_lost2 += lost2;
      n_bad2  += done2 & bad2;
      n_derr2 += dv2 & derr2;
      n_done2 += done2;
    end
  end
  task hs(input bit two);
    int n;
    n = 0;
    while ((two ? lnk2.ready : usr_ready) !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      $display("ERROR %0t: handshake timed out", $time);
    end
    @(negedge ref_clk);
    if (two) begin
      lnk2.valid = 1'b0;
      lnk2.data  = ~lnk2.data;
    end else usr_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task hdr(input logic [2:0] f, input logic s, input logic [6:0] c);
    cmd_flow   = f;
    cmd_seq_ok = s;
    cmd_count  = c;
    flow       = f;
    exp_w.push_back({c == 7'h0, 2'h0, 1'b0, s, 2'h0, f, 2'h0, c, 16'h0});
    exp_m.push_back({1'b1, 2'h0, 16'hFFFF, 16'h0});
    exp_h.push_back({f, s, 1'b0});
    usr_valid = 1'b1;
    hs(1'b0);
  endtask
  task dsc(input seg_kind_e k, input logic b, input logic e, input logic [13:0] l,
           input logic [7:0] ch, input logic [3:0] p, input logic rerr);
    logic [3:0] pe;
    logic       blk;
    blk          = k == SEG_PLC_MB;
    pe           = blk ? PROF_MB : (k == SEG_OFDM && b) ? p : PROF_ZERO;
    desc_kind    = k;
    desc_begin   = b;
    desc_end     = e;
    desc_len     = l;
    desc_chan    = ch;
    desc_profile = p;
    exp_w.push_back({3'h0, b, e & !blk, l, ch, cs[{flow, ch}], pe});
    exp_m.push_back('1);
    exp_d.push_back({ch, l, b & !blk, e & !blk, blk, b & blk, rerr, pe});
    cs[{flow, ch}]++;
    usr_valid = 1'b1;
    hs(1'b0);
  endtask
  task pay(input int n, input logic [1:0] t, input logic bad);
    for (int i = 0; i < n; i++) begin
      pseq++;
      pay_data = {4{pseq}};
      pay_last = i == n - 1;
      pay_tail = t;
      exp_w.push_back({pay_last, pay_tail, pay_data});
      exp_m.push_back({1'b1, {2{pay_last}}, 32'hFFFFFFFF});
      exp_p.push_back({pay_last, pay_last ? t : 2'h0, pay_data});
      usr_valid = 1'b1;
      hs(1'b0);
    end
    exp_b.push_back(bad);
  endtask
  task w2(input logic [31:0] d, input logic l);
    lnk2.data  = d;
    lnk2.last  = l;
    lnk2.valid = 1'b1;
    hs(1'b1);
  endtask
  task fin(input string s);
    int n;
    n = 0;
    while ((exp_w.size() + exp_p.size() + exp_d.size() + exp_h.size() + exp_b.size()) != 0
           && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      $display("ERROR %0t: expected results not drained", $time);
    end
    repeat (4) @(negedge ref_clk);
    $display("test %s done, errors %0d", s, error_cnt);
  endtask
  task end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #20000;
    error_cnt++;
    $display("ERROR %0t: run timed out", $time);
    end_sim();
  end
  initial begin
    {ref_clk, usr_valid, cmd_seq_ok, desc_begin, desc_end, pay_last, pay_ready} = '0;
    {cmd_flow, cmd_count, desc_len, desc_chan, desc_profile, pay_data, pay_tail} = '0;
    {lnk2.valid, lnk2.data, lnk2.last, lnk2.tail} = '0;
    desc_kind = SEG_SCQAM;
    sys_rst = 1'b1;
    plc_chan_en = 1'b1;
    plc_chan = 8'h09;
    {pseq, tx_err, n_hdr2, n_lost2, n_bad2, n_derr2, n_done2} = '0;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    hdr(3'h3, 1'b1, 7'h2);
    dsc(SEG_SCQAM, 1'b1, 1'b1, 14'h8, 8'h05, 4'h7, 1'b0);
    dsc(SEG_OFDM, 1'b1, 1'b0, 14'h6, 8'h07, 4'h3, 1'b0);
    pay(4, 2'h2, 1'b0);
    fin("frames");
    hdr(3'h3, 1'b0, 7'h3);
    dsc(SEG_OFDM, 1'b0, 1'b1, 14'h4, 8'h07, 4'hF, 1'b0);
    dsc(SEG_PLC_MB, 1'b1, 1'b1, 14'h8, 8'h09, 4'h0, 1'b0);
    dsc(SEG_PLC_MAC, 1'b1, 1'b1, 14'h4, 8'h09, 4'h0, 1'b0);
    pay(4, 2'h0, 1'b0);
    fin("blocks");
    hdr(3'h3, 1'b1, 7'h0);
    exp_b.push_back(1'b0);
    fin("empty");
    hdr(3'h2, 1'b1, 7'h3);
    dsc(SEG_SCQAM, 1'b1, 1'b1, 14'h4, 8'h0B, 4'h0, 1'b0);
    dsc(SEG_SCQAM, 1'b0, 1'b0, 14'h4, 8'h0B, 4'h0, 1'b1);
    dsc(SEG_SCQAM, 1'b1, 1'b0, 14'h4, 8'h0B, 4'h0, 1'b1);
    pay(3, 2'h0, 1'b0);
    hdr(3'h2, 1'b0, 7'h1);
    dsc(SEG_SCQAM, 1'b0, 1'b1, 14'h4, 8'h0B, 4'h0, 1'b0);
    pay(2, 2'h0, 1'b1);
    fin("split");
    chk(tx_err, 4'h1);
    w2(32'h4000000A, 1'b1);
    w2(32'h4001000C, 1'b0);
    w2(32'hC0080100, 1'b0);
    w2(32'h11111111, 1'b1);
    w2(32'h50000000, 1'b1);
    w2(32'h00010000, 1'b0);
    w2(32'hC0040150, 1'b0);
    w2(32'h22222222, 1'b1);
    fin("faults");
    chk({n_hdr2, n_lost2, n_bad2, n_derr2, n_done2}, {4'h3, 4'h1, 4'h2, 4'h1, 4'h4});
    end_sim();
  end
endmodule
